/* ppp_regs.vh */
`ifndef PPP_REGS_VH
`define PPP_REGS_VH

// Action selector codes on the two select pins
`define PPP_ACT_ADDR     2'h0
`define PPP_ACT_DATA     2'h1
`define PPP_ACT_CMD      2'h2
`define PPP_ACT_IDLE     2'h3

// Command bytes
`define PPP_CMD_ERASE    8'h80
`define PPP_CMD_WR_FUSE  8'h40
`define PPP_CMD_WR_LOCK  8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EE    8'h11
`define PPP_CMD_RD_SIG   8'h08
`define PPP_CMD_RD_FUSE  8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EE    8'h03

// Erased array content
`define PPP_ERASED_BYTE  8'hFF

// User operation codes
`define PPP_OP_ENTER     3'h0
`define PPP_OP_EXIT      3'h1
`define PPP_OP_ERASE     3'h2
`define PPP_OP_WR_FLASH  3'h3
`define PPP_OP_RD_FUSE   3'h4
`define PPP_OP_RD_FLASH  3'h5

// Times in ns
`define PPP_CLK_NS       25'h0000028
`define PPP_CLK_M1       25'h0000027
`define PPP_T_RST_NS     25'h0000064
`define PPP_T_BS_NS      25'h0000064
`define PPP_T_LOAD_NS    25'h0000050
`define PPP_T_WR_NS      25'h0000050
`define PPP_T_RD_NS      25'h00000A0
`define PPP_T_ERASE_NS   25'h0989680
`define PPP_T_BUSY_NS    25'h1312D00

// Counter width and one-cycle count
`define PPP_CNT_W        25
`define PPP_CNT_ONE      25'h0000001

`endif

/* ppp_buf2.v */
`timescale 1ns/10ps
module ppp_buf2 (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_in_valid,
   output wire       o_in_ready,
   input  wire [7:0] i_in_data,
   output reg        o_out_valid,
   input  wire       i_out_ready,
   output reg  [7:0] o_out_data
);
   reg        tail_v_ff;
   reg  [7:0] tail_ff;
   wire       push;
   wire       pop;

   // Ready drops only when both entries hold data
   assign o_in_ready = ~tail_v_ff;
   assign push       = i_in_valid & ~tail_v_ff;
   assign pop        = o_out_valid & i_out_ready;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_out_valid <= 1'b0;
         o_out_data  <= 8'h00;
         tail_v_ff   <= 1'b0;
         tail_ff     <= 8'h00;
      end else if (pop) begin
         if (tail_v_ff) begin
            o_out_data <= tail_ff;
            if (push) begin
               tail_ff <= i_in_data;
            end else begin
               tail_v_ff <= 1'b0;
            end
         end else begin
            o_out_valid <= push;
            o_out_data  <= i_in_data;
         end
      end else if (push) begin
         if (!o_out_valid) begin
            o_out_valid <= 1'b1;
            o_out_data  <= i_in_data;
         end else begin
            tail_v_ff <= 1'b1;
            tail_ff   <= i_in_data;
         end
      end
   end
endmodule // ppp_buf2

/* ppp_host.v */
// Functional notes
// R01: Device enables serial download only while its serial download fuse reads 0.
// R02: Device clocks from internal RC when its oscillator fuse is 0.
// R03: Fuses unreachable serially; chip erase leaves fuses unchanged.
// R04: Device holds three identification bytes at locations 0 to 2.
// R05: With both locks set, serial identification read returns 0, 1, 2.
// R06: New flash and EEPROM read as all ones.
// R07: Flash and EEPROM are programmed one byte at a time.
// R08: Load strobe acts on selector: 00 address, 01 data, 10 command, 11 none.
// R09: Byte select picks high (1) or low (0) address or data byte.
// R10: Command 80h is chip erase, loaded with selector 10 and select low.
// R11: Command 10h is write flash, loaded like other commands.
// R12: Command 04h reads fuse and lock bits.
// R13: Hold reset and byte select low 100 ns, then apply high voltage.
// R14: Byte select must stay still 100 ns after high voltage arrives.
// R15: Chip erase clears arrays, then releases lock bits.
// R16: Programmer erases the chip before reprogramming flash or EEPROM.
// R17: Erase runs on a write strobe pulse; ready/busy stays unchanged.
// R18: Write strobe after data load programs byte, ready/busy low until done.
// R19: Programmer waits for ready/busy high before the next byte.
// R20: Flash address high byte is 0 or 1, low byte full range.
// R21: Device keeps command and address across operations.
// R22: Reload address high byte only when entering a new 256-word page.
// R23: Skip writing all-ones bytes.
// R24: Device captures selector, byte select and data on load strobe rise.
`timescale 1ns/10ps
`include "ppp_regs.vh"
module ppp_host #(
   parameter [`PPP_CNT_W-1:0] ERASE_CYC = (`PPP_T_ERASE_NS + `PPP_CLK_M1) / `PPP_CLK_NS,
   parameter [`PPP_CNT_W-1:0] BUSY_CYC  = `PPP_T_BUSY_NS / `PPP_CLK_NS
) (
   input  wire       I_CLK,
   input  wire       I_RST,
   input  wire       I_CMD_VALID,
   output reg        O_CMD_READY,
   input  wire [2:0] I_CMD_OP,
   input  wire [8:0] I_CMD_ADDR,
   input  wire       I_CMD_HIGH,
   input  wire [7:0] I_CMD_DATA,
   output wire       O_RD_VALID,
   input  wire       I_RD_READY,
   output wire [7:0] O_RD_DATA,
   output reg        O_DONE,
   output reg        O_REFUSED,
   output reg        O_TIMEOUT,
   output reg        O_PROG_MODE,
   output reg        O_RESET_N,
   output reg        O_HV_EN,
   output reg        O_ACTION_SELECT_HI,
   output reg        O_ACTION_SELECT_LO,
   output reg        O_BYTE_HALF_SELECT,
   output reg        O_LOAD_STROBE_PIN,
   output reg        O_WRITE_STROBE_N,
   output reg        O_READ_ENABLE_N,
   output reg  [7:0] O_DATA_OUT,
   output reg        O_DATA_OE,
   input  wire [7:0] I_DATA_IN,
   input  wire       I_READY_BUSY_OUT
);
   localparam [`PPP_CNT_W-1:0] RST_CYC  = (`PPP_T_RST_NS + `PPP_CLK_M1) / `PPP_CLK_NS;
   localparam [`PPP_CNT_W-1:0] BS_CYC   = (`PPP_T_BS_NS + `PPP_CLK_M1) / `PPP_CLK_NS;
   localparam [`PPP_CNT_W-1:0] LOAD_CYC = (`PPP_T_LOAD_NS + `PPP_CLK_M1) / `PPP_CLK_NS;
   localparam [`PPP_CNT_W-1:0] WR_CYC   = (`PPP_T_WR_NS + `PPP_CLK_M1) / `PPP_CLK_NS;
   localparam [`PPP_CNT_W-1:0] RD_CYC   = (`PPP_T_RD_NS + `PPP_CLK_M1) / `PPP_CLK_NS;

   localparam [3:0] S_IDLE   = 4'h0;
   localparam [3:0] S_ENT_LO = 4'h1;
   localparam [3:0] S_ENT_HV = 4'h2;
   localparam [3:0] S_PLAN   = 4'h3;
   localparam [3:0] S_LD_SET = 4'h4;
   localparam [3:0] S_LD_HI  = 4'h5;
   localparam [3:0] S_LD_LO  = 4'h6;
   localparam [3:0] S_WR     = 4'h7;
   localparam [3:0] S_WT_LO  = 4'h8;
   localparam [3:0] S_WT_HI  = 4'h9;
   localparam [3:0] S_RD     = 4'hA;
   localparam [3:0] S_RD_CAP = 4'hB;
   localparam [3:0] S_FINISH = 4'hC;

   reg [3:0]            state_ff;
   reg [`PPP_CNT_W-1:0] cnt_ff;
   reg [2:0]            op_ff;
   reg [8:0]            addr_ff;
   reg                  high_ff;
   reg [7:0]            data_ff;
   reg [7:0]            cmd_cur_ff;
   reg                  cmd_known_ff;
   reg                  ahi_cur_ff;
   reg                  ahi_known_ff;
   reg                  erased_ff;
   reg                  need_cmd_ff;
   reg                  need_ahi_ff;
   reg                  need_alo_ff;
   reg                  need_dat_ff;
   reg                  rdy_meta_ff;
   reg                  rdy_sync_ff;
   reg [7:0]            din_meta_ff;
   reg [7:0]            din_sync_ff;
   reg                  buf_valid_ff;
   wire                 buf_ready;

   // Command byte belonging to each user operation
   function [7:0] op_cmd;
      input [2:0] op;
      begin
         case (op)
            `PPP_OP_ERASE:    op_cmd = `PPP_CMD_ERASE;    // [R10]
            `PPP_OP_WR_FLASH: op_cmd = `PPP_CMD_WR_FLASH; // [R11]
            `PPP_OP_RD_FUSE:  op_cmd = `PPP_CMD_RD_FUSE;  // [R12]
            `PPP_OP_RD_FLASH: op_cmd = `PPP_CMD_RD_FLASH;
            default:          op_cmd = `PPP_CMD_RD_SIG;
         endcase
      end
   endfunction

   // Operations that carry a flash address
   function op_addr;
      input [2:0] op;
      begin
         op_addr = (op == `PPP_OP_WR_FLASH) || (op == `PPP_OP_RD_FLASH);
      end
   endfunction

   // Pins from the device pass two flops before use
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdy_meta_ff <= 1'b1;
         rdy_sync_ff <= 1'b1;
         din_meta_ff <= 8'h00;
         din_sync_ff <= 8'h00;
      end else begin
         rdy_meta_ff <= I_READY_BUSY_OUT;
         rdy_sync_ff <= rdy_meta_ff;
         din_meta_ff <= I_DATA_IN;
         din_sync_ff <= din_meta_ff;
      end
   end

   // Read bytes wait here so a stalled receiver loses none
   ppp_buf2 u_buf (
      .i_clk       (I_CLK),
      .i_rst       (I_RST),
      .i_in_valid  (buf_valid_ff),
      .o_in_ready  (buf_ready),
      .i_in_data   (din_sync_ff),
      .o_out_valid (O_RD_VALID),
      .i_out_ready (I_RD_READY),
      .o_out_data  (O_RD_DATA)
   );

   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_ff           <= S_IDLE;
         cnt_ff             <= {`PPP_CNT_W{1'b0}};
         op_ff              <= `PPP_OP_ENTER;
         addr_ff            <= 9'h000;
         high_ff            <= 1'b0;
         data_ff            <= 8'h00;
         cmd_cur_ff         <= 8'h00;
         cmd_known_ff       <= 1'b0;
         ahi_cur_ff         <= 1'b0;
         ahi_known_ff       <= 1'b0;
         erased_ff          <= 1'b0;
         need_cmd_ff        <= 1'b0;
         need_ahi_ff        <= 1'b0;
         need_alo_ff        <= 1'b0;
         need_dat_ff        <= 1'b0;
         buf_valid_ff       <= 1'b0;
         O_CMD_READY        <= 1'b0;
         O_DONE             <= 1'b0;
         O_REFUSED          <= 1'b0;
         O_TIMEOUT          <= 1'b0;
         O_PROG_MODE        <= 1'b0;
         O_RESET_N          <= 1'b1;
         O_HV_EN            <= 1'b0;
         O_ACTION_SELECT_HI <= 1'b1;
         O_ACTION_SELECT_LO <= 1'b1;
         O_BYTE_HALF_SELECT <= 1'b0;
         O_LOAD_STROBE_PIN  <= 1'b0;
         O_WRITE_STROBE_N   <= 1'b1;
         O_READ_ENABLE_N    <= 1'b1;
         O_DATA_OUT         <= 8'h00;
         O_DATA_OE          <= 1'b0;
      end else begin
         O_DONE       <= 1'b0;
         O_REFUSED    <= 1'b0;
         O_TIMEOUT    <= 1'b0;
         buf_valid_ff <= 1'b0;
         O_CMD_READY  <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               O_CMD_READY <= ~(I_CMD_VALID & O_CMD_READY);
               if (I_CMD_VALID && O_CMD_READY) begin
                  op_ff   <= I_CMD_OP;
                  addr_ff <= I_CMD_ADDR;
                  high_ff <= I_CMD_HIGH;
                  data_ff <= I_CMD_DATA;
                  // Device keeps command and page address; reload only on change
                  need_cmd_ff <= !cmd_known_ff || (cmd_cur_ff != op_cmd(I_CMD_OP)); // [R21]
                  need_ahi_ff <= op_addr(I_CMD_OP) &&
                                 (!ahi_known_ff || (ahi_cur_ff != I_CMD_ADDR[8])); // [R22]
                  need_alo_ff <= op_addr(I_CMD_OP);
                  need_dat_ff <= (I_CMD_OP == `PPP_OP_WR_FLASH);
                  if (I_CMD_OP == `PPP_OP_ENTER) begin
                     O_PROG_MODE        <= 1'b0;
                     O_HV_EN            <= 1'b0;
                     O_RESET_N          <= 1'b0;
                     O_BYTE_HALF_SELECT <= 1'b0;
                     cnt_ff             <= RST_CYC;
                     state_ff           <= S_ENT_LO; // [R13]
                  end else if (I_CMD_OP == `PPP_OP_EXIT) begin
                     O_PROG_MODE  <= 1'b0;
                     O_HV_EN      <= 1'b0;
                     O_RESET_N    <= 1'b1;
                     cmd_known_ff <= 1'b0;
                     ahi_known_ff <= 1'b0;
                     erased_ff    <= 1'b0;
                     state_ff     <= S_FINISH;
                  end else if (!O_PROG_MODE || I_CMD_OP > `PPP_OP_RD_FLASH) begin
                     O_REFUSED <= 1'b1;
                     state_ff  <= S_FINISH;
                  end else if (I_CMD_OP == `PPP_OP_WR_FLASH && !erased_ff) begin
                     O_REFUSED <= 1'b1; // [R16]
                     state_ff  <= S_FINISH;
                  end else if (I_CMD_OP == `PPP_OP_WR_FLASH &&
                               I_CMD_DATA == `PPP_ERASED_BYTE) begin
                     state_ff <= S_FINISH; // [R23]
                  end else begin
                     state_ff <= S_PLAN;
                  end
               end
            end
            S_ENT_LO: begin
               // Reset and byte select low for the least setup time
               if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  O_HV_EN  <= 1'b1; // [R13]
                  cnt_ff   <= BS_CYC;
                  state_ff <= S_ENT_HV;
               end
            end
            S_ENT_HV: begin
               // Byte select is frozen here, any change would abort entry
               if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE; // [R14]
               end else begin
                  O_PROG_MODE  <= 1'b1;
                  cmd_known_ff <= 1'b0;
                  ahi_known_ff <= 1'b0;
                  erased_ff    <= 1'b0;
                  state_ff     <= S_FINISH;
               end
            end
            S_PLAN: begin
               cnt_ff   <= LOAD_CYC;
               state_ff <= S_LD_SET;
               O_DATA_OE <= 1'b1;
               if (need_cmd_ff) begin
                  need_cmd_ff        <= 1'b0;
                  cmd_known_ff       <= 1'b1;
                  cmd_cur_ff         <= op_cmd(op_ff);
                  {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO} <= `PPP_ACT_CMD; // [R08]
                  O_BYTE_HALF_SELECT <= 1'b0; // [R10]
                  O_DATA_OUT         <= op_cmd(op_ff);
               end else if (need_ahi_ff) begin
                  need_ahi_ff        <= 1'b0;
                  ahi_known_ff       <= 1'b1;
                  ahi_cur_ff         <= addr_ff[8];
                  {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO} <= `PPP_ACT_ADDR; // [R08]
                  O_BYTE_HALF_SELECT <= 1'b1; // [R09]
                  O_DATA_OUT         <= {7'h00, addr_ff[8]}; // [R20]
               end else if (need_alo_ff) begin
                  need_alo_ff        <= 1'b0;
                  {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO} <= `PPP_ACT_ADDR;
                  O_BYTE_HALF_SELECT <= 1'b0; // [R09]
                  O_DATA_OUT         <= addr_ff[7:0]; // [R20]
               end else if (need_dat_ff) begin
                  need_dat_ff        <= 1'b0;
                  {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO} <= `PPP_ACT_DATA; // [R08]
                  O_BYTE_HALF_SELECT <= high_ff; // [R09]
                  O_DATA_OUT         <= data_ff;
               end else begin
                  {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO} <= `PPP_ACT_IDLE;
                  O_BYTE_HALF_SELECT <= high_ff;
                  if (op_ff == `PPP_OP_ERASE) begin
                     O_WRITE_STROBE_N <= 1'b0; // [R17]
                     cnt_ff           <= ERASE_CYC;
                     state_ff         <= S_WR;
                  end else if (op_ff == `PPP_OP_WR_FLASH) begin
                     O_WRITE_STROBE_N <= 1'b0; // [R18]
                     cnt_ff           <= WR_CYC;
                     state_ff         <= S_WR;
                  end else begin
                     // Bus released in the same cycle that read enable goes low
                     O_DATA_OE       <= 1'b0;
                     O_READ_ENABLE_N <= 1'b0;
                     cnt_ff          <= RD_CYC;
                     state_ff        <= S_RD;
                  end
               end
            end
            S_LD_SET: begin
               // One cycle of setup so pins are stable at the rising edge
               O_LOAD_STROBE_PIN <= 1'b1; // [R24]
               state_ff          <= S_LD_HI;
            end
            S_LD_HI: begin
               if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  O_LOAD_STROBE_PIN <= 1'b0;
                  state_ff          <= S_LD_LO;
               end
            end
            S_LD_LO: begin
               // Hold pins two cycles past the falling strobe
               state_ff <= S_PLAN;
            end
            S_WR: begin
               if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  O_WRITE_STROBE_N <= 1'b1;
                  cnt_ff           <= BUSY_CYC;
                  if (op_ff == `PPP_OP_ERASE) begin
                     // Erase gives no ready/busy activity; pulse width is the whole wait
                     erased_ff <= 1'b1; // [R17]
                     state_ff  <= S_FINISH;
                  end else begin
                     state_ff <= S_WT_LO;
                  end
               end
            end
            S_WT_LO: begin
               if (!rdy_sync_ff) begin
                  cnt_ff   <= BUSY_CYC;
                  state_ff <= S_WT_HI; // [R18]
               end else if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  O_TIMEOUT <= 1'b1;
                  state_ff  <= S_FINISH;
               end
            end
            S_WT_HI: begin
               // Next byte only after ready returns high
               if (rdy_sync_ff) begin
                  state_ff <= S_FINISH; // [R19]
               end else if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  O_TIMEOUT <= 1'b1;
                  state_ff  <= S_FINISH;
               end
            end
            S_RD: begin
               // Covers device access time only; S_RD_CAP and the buffer push absorb the two-flop input delay
               if (cnt_ff > `PPP_CNT_ONE) begin
                  cnt_ff <= cnt_ff - `PPP_CNT_ONE;
               end else begin
                  state_ff <= S_RD_CAP;
               end
            end
            S_RD_CAP: begin
               // Stalls here while the read buffer is full
               if (buf_ready) begin
                  buf_valid_ff    <= 1'b1;
                  O_READ_ENABLE_N <= 1'b1;
                  state_ff        <= S_FINISH;
               end
            end
            S_FINISH: begin
               O_DONE      <= 1'b1;
               O_CMD_READY <= 1'b1;
               state_ff    <= S_IDLE;
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
endmodule // ppp_host

/* ppp_monitor.sv */
`timescale 1ns/10ps
`include "ppp_regs.vh"
module ppp_monitor #(
   parameter [`PPP_CNT_W-1:0] ERASE_CYC = 25'h0000014,
   parameter [`PPP_CNT_W-1:0] BUSY_CYC  = 25'h0000032
) (
   input wire       I_CLK,
   input wire       I_RST,
   input wire       I_READY_BUSY_OUT,
   input wire       O_DONE,
   input wire       O_REFUSED,
   input wire       O_RESET_N,
   input wire       O_HV_EN,
   input wire       O_ACTION_SELECT_HI,
   input wire       O_ACTION_SELECT_LO,
   input wire       O_BYTE_HALF_SELECT,
   input wire       O_LOAD_STROBE_PIN,
   input wire       O_WRITE_STROBE_N,
   input wire       O_READ_ENABLE_N,
   input wire [7:0] O_DATA_OUT,
   input wire       O_DATA_OE
);
   wire [1:0] sel;
   assign sel = {O_ACTION_SELECT_HI, O_ACTION_SELECT_LO};
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   AST_LOAD_ACT:
      assert property ($rose(O_LOAD_STROBE_PIN) |-> sel != `PPP_ACT_IDLE && O_DATA_OE)
      else $error("load strobe without action");
   AST_LOAD_HOLD:
      assert property (O_LOAD_STROBE_PIN && $past(O_LOAD_STROBE_PIN)
         |-> $stable({sel, O_BYTE_HALF_SELECT, O_DATA_OUT})) else $error("load inputs moved");
   AST_CMD_LOW:
      assert property ($rose(O_LOAD_STROBE_PIN) && sel == `PPP_ACT_CMD |-> !O_BYTE_HALF_SELECT)
      else $error("command loaded with high half");
   AST_ADDR_HI:
      assert property ($rose(O_LOAD_STROBE_PIN) && sel == `PPP_ACT_ADDR && O_BYTE_HALF_SELECT
         |-> O_DATA_OUT[7:1] == 7'h00) else $error("address high byte above 1");
   AST_ENTRY:
      assert property ($rose(O_HV_EN) |-> !O_BYTE_HALF_SELECT && $past(O_RESET_N, 3) == 1'b0)
      else $error("high voltage too early");
   AST_BS_QUIET:
      assert property ($rose(O_HV_EN) |-> $stable(O_BYTE_HALF_SELECT) [*4])
      else $error("byte select moved after high voltage");
   AST_WR_IDLE:
      assert property (!O_WRITE_STROBE_N |-> sel == `PPP_ACT_IDLE && !O_LOAD_STROBE_PIN)
      else $error("write strobe during load");
   AST_WR_WIDTH:
      assert property ($fell(O_WRITE_STROBE_N) |-> !O_WRITE_STROBE_N [*2])
      else $error("write pulse too short");
   AST_WR_RDY:
      assert property ($fell(O_WRITE_STROBE_N) |-> $past(I_READY_BUSY_OUT, 3))
      else $error("write while device busy");
   AST_REFUSE:
      assert property (O_REFUSED |-> O_WRITE_STROBE_N && !O_LOAD_STROBE_PIN ##1 O_DONE)
      else $error("refusal with pin activity");
   AST_RD_BUS:
      assert property ($fell(O_READ_ENABLE_N) |-> !O_DATA_OE && sel == `PPP_ACT_IDLE)
      else $error("read with bus driven");
endmodule // ppp_monitor
bind ppp_host ppp_monitor #(.ERASE_CYC(ERASE_CYC), .BUSY_CYC(BUSY_CYC)) i_ppp_monitor (.*);

/* ppp_dev.sv */
`timescale 1ns/10ps
`include "ppp_regs.vh"
module ppp_dev (
   input  wire       i_reset_n,
   input  wire       i_hv_en,
   input  wire [1:0] i_sel,
   input  wire       i_bs,
   input  wire       i_load,
   input  wire       i_wr_n,
   input  wire       i_re_n,
   input  wire [7:0] i_data,
   input  wire       i_slow,
   output reg  [7:0] o_data,
   output reg        o_rdy
);
   reg [15:0] mem [0:511];
   reg [15:0] w;
   reg [7:0]  cmd_ff, al_ff, dat_ff, val;
   reg        ah_ff, prog, hb;
   reg        ser_fuse = 1'b0;
   reg        osc_fuse = 1'b1;
   reg [1:0]  lock = 2'h3;
   time       t_lo = 64'h000000FFFFFFFFFF;
   time       t_hv = 0;
   integer    i;
   wire [8:0] a = {ah_ff, al_ff};
   initial begin
      for (i = 0; i < 512; i = i + 1) mem[i] = 16'hFFFF;
      prog = 1'b0;
      o_rdy = 1'b1;
      {cmd_ff, al_ff, dat_ff, ah_ff} = 25'h0000000;
   end
   always @(negedge i_reset_n) t_lo = $time;
   always @(posedge i_hv_en) begin
      t_hv = $time;
      prog = !i_bs && ($time >= t_lo + 100);
   end
   always @(negedge i_hv_en) prog = 1'b0;
   always @(i_bs) if (i_hv_en && $time < t_hv + 100) prog = 1'b0;
   always @(posedge i_load) begin
      if (prog && i_sel == `PPP_ACT_CMD) cmd_ff = i_data;
      if (prog && i_sel == `PPP_ACT_DATA) dat_ff = i_data;
      if (prog && i_sel == `PPP_ACT_ADDR && i_bs) ah_ff = i_data[0];
      if (prog && i_sel == `PPP_ACT_ADDR && !i_bs) al_ff = i_data;
   end
   // Programming only clears bits, like real flash cells
   always @(negedge i_wr_n) if (prog && cmd_ff == `PPP_CMD_WR_FLASH) begin
      hb = i_bs;
      o_rdy = 1'b0;
      #(i_slow ? 1200 : 200);
      mem[a] = mem[a] & (hb ? {dat_ff, 8'hFF} : {8'hFF, dat_ff});
      o_rdy = 1'b1;
   end
   always @(posedge i_wr_n) if (prog && cmd_ff == `PPP_CMD_ERASE) begin
      for (i = 0; i < 512; i = i + 1) mem[i] = 16'hFFFF;
      lock = 2'h3;
   end
   // Released bus shows the inverse, never a stale copy
   always @* begin
      w = mem[a];
      val = i_bs ? w[15:8] : w[7:0];
      if (cmd_ff == `PPP_CMD_RD_FUSE)
         val = {4'hF, lock, osc_fuse, ser_fuse};
      if (cmd_ff == `PPP_CMD_RD_SIG)
         val = (al_ff < 8'h03) ? (8'hC0 | al_ff) : 8'h00; // Arbitrary code
      o_data = (prog && !i_re_n) ? val : ~val;
   end
endmodule // ppp_dev

/* tb_top.sv */
`timescale 1ns/10ps
`include "ppp_regs.vh"
module tb_top;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         cv = 1'b0;
   reg         hi = 1'b0;
   reg         hold = 1'b1;
   reg         slow = 1'b0;
   reg         rd_rdy = 1'b0;
   reg         rf = 1'b0;
   reg  [2:0]  op = 3'h0;
   reg  [8:0]  addr = 9'h000;
   reg  [7:0]  dat = 8'h00;
   reg  [31:0] rnd = 32'h00000000;
   reg  [31:0] rr = 32'h00000000;
   reg  [15:0] shm [0:511];
   reg         exq [$];
   reg  [7:0]  rdq [$];
   wire        crdy, rvld, done, refd, pm, rst_n, hv, sh, sl, bs, ld, wr_n, re_n, oe, rdy, tmo;
   wire [7:0]  rdat, dout, dq, din;
   integer     seed = 32'h50D32A50;
   integer     err_count = 0;
   integer     checks = 0;
   integer     cyc = 0, ncmd = 0, nah = 0, nwr = 0, n0, n1, i;
   assign din = oe ? dout : dq;
   always #20 clk = ~clk;
   ppp_host #(.ERASE_CYC(25'h0000014), .BUSY_CYC(25'h0000032)) i_ppp_host (
      .I_CLK(clk), .I_RST(rst), .I_CMD_VALID(cv), .O_CMD_READY(crdy), .I_CMD_OP(op),
      .I_CMD_ADDR(addr), .I_CMD_HIGH(hi), .I_CMD_DATA(dat), .O_RD_VALID(rvld),
      .I_RD_READY(rd_rdy), .O_RD_DATA(rdat), .O_DONE(done), .O_REFUSED(refd), .O_TIMEOUT(tmo),
      .O_PROG_MODE(pm), .O_RESET_N(rst_n), .O_HV_EN(hv), .O_ACTION_SELECT_HI(sh),
      .O_ACTION_SELECT_LO(sl), .O_BYTE_HALF_SELECT(bs), .O_LOAD_STROBE_PIN(ld),
      .O_WRITE_STROBE_N(wr_n), .O_READ_ENABLE_N(re_n), .O_DATA_OUT(dout), .O_DATA_OE(oe),
      .I_DATA_IN(din), .I_READY_BUSY_OUT(rdy));
   ppp_dev i_ppp_dev (.i_reset_n(rst_n), .i_hv_en(hv), .i_sel({sh, sl}), .i_bs(bs),
      .i_load(ld), .i_wr_n(wr_n), .i_re_n(re_n), .i_data(din), .i_slow(slow), .o_data(dq),
      .o_rdy(rdy));
   task end_sim;
      begin
         if (err_count == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input ok, input [8*20-1:0] msg);
      begin
         checks = checks + 1;
         if (!ok) begin
            err_count = err_count + 1;
            $display("[ERR] %0t %0s", $time, msg);
         end
      end
   endtask
   task run(input [2:0] o, input [8:0] a, input h, input [7:0] d, input r);
      begin
         @(negedge clk);
         {op, addr, hi, dat, cv} = {o, a, h, d, 1'b1};
         exq.push_back(r);
         while (crdy !== 1'b1) @(negedge clk);
         @(negedge clk);
         cv = 1'b0;
      end
   endtask
   task wait_rdy;
      while (crdy !== 1'b1) @(negedge clk);
   endtask
   task wr(input [8:0] a, input h, input [7:0] d);
      begin
         run(`PPP_OP_WR_FLASH, a, h, d, 1'b0);
         shm[a] = shm[a] & (h ? {d, 8'hFF} : {8'hFF, d});
      end
   endtask
   task rd(input [8:0] a, input h);
      begin
         rdq.push_back(h ? shm[a][15:8] : shm[a][7:0]);
         run(`PPP_OP_RD_FLASH, a, h, 8'h00, 1'b0);
      end
   endtask
   always @(posedge ld) begin
      if ({sh, sl} == `PPP_ACT_CMD) ncmd = ncmd + 1;
      if ({sh, sl} == `PPP_ACT_ADDR && bs) nah = nah + 1;
   end
   always @(negedge wr_n) nwr = nwr + 1;
   // Results are compared in order of issue
   always @(negedge clk) begin
      rr = $random(seed);
      rd_rdy = hold ? 1'b0 : rr[0];
      if (done === 1'b1) begin
         if (exq.size() == 0) chk(1'b0, "stray done");
         else chk(rf === exq.pop_front(), "refusal flag");
      end
      rf = (refd === 1'b1);
      if (tmo !== 1'b0) chk(1'b0, "busy timeout");
      if (rvld === 1'b1 && rd_rdy === 1'b1) begin
         if (rdq.size() == 0) chk(1'b0, "stray byte");
         else chk(rdat === rdq.pop_front(), "read byte");
      end
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         end_sim;
      end
   end
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      hold = 1'b0;
      run(`PPP_OP_ERASE, 9'h000, 1'b0, 8'h00, 1'b1);
      run(3'h6, 9'h000, 1'b0, 8'h00, 1'b1);
      run(`PPP_OP_ENTER, 9'h000, 1'b0, 8'h00, 1'b0);
      wait_rdy;
      chk(pm === 1'b1, "prog mode");
      run(`PPP_OP_WR_FLASH, 9'h005, 1'b0, 8'h3C, 1'b1);
      run(`PPP_OP_ERASE, 9'h000, 1'b0, 8'h00, 1'b0);
      for (i = 0; i < 512; i = i + 1) shm[i] = 16'hFFFF;
      rdq.push_back(8'hFE);
      run(`PPP_OP_RD_FUSE, 9'h000, 1'b0, 8'h00, 1'b0);
      for (i = 0; i < 6; i = i + 1) begin
         rnd = $random(seed);
         slow = rnd[12];
         wr(rnd[8:0], rnd[9], rnd[23:16]);
         rd(rnd[8:0], rnd[9]);
      end
      wr(9'h1A0, 1'b1, 8'h5A);
      wait_rdy;
      {n0, n1} = {ncmd, nah};
      wr(9'h1A1, 1'b0, 8'hA5);
      wait_rdy;
      chk(ncmd == n0 && nah == n1, "needless reload");
      n0 = nwr;
      wr(9'h033, 1'b0, 8'hFF);
      wait_rdy;
      chk(nwr == n0, "erased byte write");
      hold = 1'b1;
      rd(9'h1A0, 1'b1);
      rd(9'h1A1, 1'b0);
      fork
         begin
            repeat (60) @(negedge clk);
            hold = 1'b0;
         end
      join_none
      rd(9'h1A0, 1'b0);
      run(`PPP_OP_EXIT, 9'h000, 1'b0, 8'h00, 1'b0);
      wait_rdy;
      chk(pm === 1'b0, "exit");
      run(`PPP_OP_WR_FLASH, 9'h005, 1'b0, 8'h12, 1'b1);
      while (exq.size() != 0 || rdq.size() != 0) @(negedge clk);
      end_sim;
   end
endmodule // tb_top
